// *** shared/ttp_consts.svh ***
// Register offsets, field positions, reset values and timing counts of the time-tag block.
`ifndef TTP_CONSTS_SVH
`define TTP_CONSTS_SVH

`define TTP_REG_CTRL 8'h00
`define TTP_REG_STATUS 8'h04
`define TTP_REG_MASK 8'h08
`define TTP_REG_PERIOD 8'h0c
`define TTP_REG_START_DATE 8'h10
`define TTP_REG_START_TIME 8'h14
`define TTP_REG_SET_DATE 8'h18
`define TTP_REG_SET_TIME 8'h1c
`define TTP_REG_CHAR_SEL 8'h20
`define TTP_REG_CHAR_DATA 8'h24
`define TTP_REG_USEC 8'h28
`define TTP_CAP_WIN 2'h1

`define TTP_CTRL_ASCII 0
`define TTP_CTRL_CONT 1
`define TTP_CTRL_CLEAR 2
`define TTP_CTRL_LOAD 3
`define TTP_STAT_PULSE 3
`define TTP_SEL_IDX_LSB 8

`define TTP_DATE_YEAR_LSB 16
`define TTP_DATE_MON_LSB 8
`define TTP_DATE_DAY_LSB 0
`define TTP_TIME_HOUR_LSB 16
`define TTP_TIME_MIN_LSB 8
`define TTP_TIME_SEC_LSB 0

`define TTP_PERIOD_RST 32'h0000_0001
`define TTP_MONTH_RST 4'h1
`define TTP_DAY_RST 5'h01
`define TTP_TC_CH 2'h3

`define TTP_CLK_PERIOD_NS 10
`define TTP_USEC_NS 1000
`define TTP_CYC_PER_USEC (`TTP_USEC_NS / `TTP_CLK_PERIOD_NS)
`define TTP_PULSE_WIDTH_US 20
`define TTP_PULSE_CYCLES (`TTP_PULSE_WIDTH_US * `TTP_CYC_PER_USEC)
`define TTP_USEC_PER_SEC 1000000

`endif

// *** shared/ttp_pkg.sv ***
// Types shared by the time-tag block.
package ttp_pkg;
    typedef struct packed {
        logic [15:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
        logic [19:0] usec;
    } ttp_tod_t;

    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_ARMED = 2'b01,
        PS_RUN = 2'b10
    } ttp_ps_t;
endpackage : ttp_pkg

// *** logic/ttp_cap_mem.sv ***
// Small capture record memory with per-entry write enables and a registered read port.
`timescale 1ns/1ps
module ttp_cap_mem #(
    parameter int WIDTH = 62,
    parameter int DEPTH = 3,
    parameter int AW = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [DEPTH-1:0] we,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] q;
    } ttp_mem_state_t;

    ttp_mem_state_t r, r_nxt;

    // Each entry takes the shared write data when its own enable is high.
    always_comb begin
        r_nxt = r;
        for (int i = 0; i < DEPTH; i++) begin
            if (we[i]) begin
                r_nxt.mem[i] = wdata;
            end
        end
        r_nxt.q = (32'(raddr) < DEPTH) ? r.mem[raddr] : '0;
    end

    // Only the read register is reset; entry contents are qualified elsewhere.
    always_ff @(posedge clk) begin
        r <= r_nxt;
        if (reset) begin
            r.q <= '0;
        end
    end

    assign rdata = r.q;
endmodule : ttp_cap_mem

// *** logic/ttp_scheduler.sv ***
// Time-of-day keeper with three event capture channels and a scheduled pulse train.
// Function
// - Three event inputs each store a time tag in their own capture record.
// - Capture-clear command discards every stored record in all channels.
// - ASCII format makes capture records readable as text characters.
// - Record text is yyyy,mm,dd,hh,mm,ssssssss,xxxxxxxx.
// - Time-code query string starts with T, then current date and time.
// - Pulse period sets whole seconds between pulses; one means every second.
// - Continuous state on gives an unbroken pulse train at the period.
// - A start moment already past starts the train at the next second boundary.
// - A future start moment holds the output idle until reached.
`timescale 1ns/1ps
`include "ttp_consts.svh"
module ttp_scheduler import ttp_pkg::*; #(
    parameter int NUM_CH = 3,
    parameter int USEC_PER_SEC = `TTP_USEC_PER_SEC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [NUM_CH-1:0] event_in,
    output logic pulse_out,
    output logic irq
);
    localparam int TOD_W = $bits(ttp_tod_t);
    localparam logic [7:0] CYC_LAST = 8'(`TTP_CYC_PER_USEC - 1);
    localparam logic [19:0] USEC_LAST = 20'(USEC_PER_SEC - 1);
    localparam logic [15:0] PW_LAST = 16'(`TTP_PULSE_CYCLES - 1);

    typedef struct packed {
        logic [NUM_CH-1:0] s1, s2, s3, stab;
        logic [7:0] cyc;
        ttp_tod_t tod;
        ttp_tod_t start;
        ttp_tod_t set;
        logic ascii, cont;
        logic [31:0] period, pcnt;
        ttp_ps_t pstate;
        logic [15:0] pw;
        logic pulse;
        logic [1:0] sel_ch;
        logic [5:0] sel_idx;
        logic [3:0] status, mask;
        logic [NUM_CH-1:0] valid;
        logic [NUM_CH-1:0][31:0] cnt;
        logic [31:0] rdata;
        logic rd_cap, rd_char;
        logic [1:0] rd_ch, rd_word;
        logic [5:0] rd_idx;
    } ttp_state_t;

    ttp_state_t r, r_nxt;
    ttp_tod_t cap_q;
    logic [TOD_W-1:0] mem_q;
    logic [1:0] mem_raddr;
    logic [NUM_CH-1:0] ev_rise;
    logic usec_tick, sec_tick, start_reached;
    ttp_tod_t tod_adv;
    logic [31:0] eff_period;
    logic [31:0] cap_word;
    logic [7:0] char_out;

    // Decimal digit p of value v.
    function automatic logic [3:0] dig(input logic [31:0] v, input logic [2:0] p);
        logic [31:0] d;
        d = v;
        case (p)
            3'h0: d = v % 10;
            3'h1: d = (v / 10) % 10;
            3'h2: d = (v / 100) % 10;
            3'h3: d = (v / 1000) % 10;
            3'h4: d = (v / 10000) % 10;
            3'h5: d = (v / 100000) % 10;
            default: d = 32'h0;
        endcase
        return d[3:0];
    endfunction : dig

    function automatic logic [7:0] asc(input logic [3:0] d);
        return 8'h30 + {4'h0, d};
    endfunction : asc

    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h57 + {4'h0, n});
    endfunction : hexc

    // Days in the month, with every fourth year a leap year.
    function automatic logic [4:0] mlen(input logic [15:0] y, input logic [3:0] m);
        case (m)
            4'h4, 4'h6, 4'h9, 4'hb: return 5'h1e;
            4'h2: return (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            default: return 5'h1f;
        endcase
    endfunction : mlen

    // True when a is at or after b, to the whole second.
    function automatic logic tod_ge(input ttp_tod_t a, input ttp_tod_t b);
        return {a.year, a.month, a.day, a.hour, a.minute, a.second} >=
               {b.year, b.month, b.day, b.hour, b.minute, b.second};
    endfunction : tod_ge

    function automatic logic [31:0] pack_date(input ttp_tod_t t);
        logic [31:0] w;
        w = '0;
        w[`TTP_DATE_YEAR_LSB +: 16] = t.year;
        w[`TTP_DATE_MON_LSB +: 4] = t.month;
        w[`TTP_DATE_DAY_LSB +: 5] = t.day;
        return w;
    endfunction : pack_date

    function automatic logic [31:0] pack_time(input ttp_tod_t t);
        logic [31:0] w;
        w = '0;
        w[`TTP_TIME_HOUR_LSB +: 5] = t.hour;
        w[`TTP_TIME_MIN_LSB +: 6] = t.minute;
        w[`TTP_TIME_SEC_LSB +: 6] = t.second;
        return w;
    endfunction : pack_time

    // Character i of a capture record: yyyy,mm,dd,hh,mm,ssssssss,xxxxxxxx.
    function automatic logic [7:0] rec_char(input ttp_tod_t t, input logic [31:0] n,
                                           input logic [5:0] i);
        logic [7:0] c;
        logic [31:0] sh;
        c = 8'h00;
        sh = n >> {6'd33 - i, 2'b00};
        if (i < 6'd4) c = asc(dig(32'(t.year), 3'(6'd3 - i)));
        else if (i == 6'd4 || i == 6'd7 || i == 6'd10 || i == 6'd13 || i == 6'd16 ||
                 i == 6'd25) c = 8'h2c;
        else if (i < 6'd7) c = asc(dig(32'(t.month), 3'(6'd6 - i)));
        else if (i < 6'd10) c = asc(dig(32'(t.day), 3'(6'd9 - i)));
        else if (i < 6'd13) c = asc(dig(32'(t.hour), 3'(6'd12 - i)));
        else if (i < 6'd16) c = asc(dig(32'(t.minute), 3'(6'd15 - i)));
        else if (i < 6'd19) c = asc(dig(32'(t.second), 3'(6'd18 - i)));
        else if (i < 6'd25) c = asc(dig(32'(t.usec), 3'(6'd24 - i)));
        else if (i < 6'd34) c = hexc(sh[3:0]);
        return c;
    endfunction : rec_char

    // Character i of the time code: T, yyyymmdd, hhmmss.
    function automatic logic [7:0] tc_char(input ttp_tod_t t, input logic [5:0] i);
        logic [7:0] c;
        c = 8'h00;
        if (i == 6'd0) c = 8'h54;
        else if (i < 6'd5) c = asc(dig(32'(t.year), 3'(6'd4 - i)));
        else if (i < 6'd7) c = asc(dig(32'(t.month), 3'(6'd6 - i)));
        else if (i < 6'd9) c = asc(dig(32'(t.day), 3'(6'd8 - i)));
        else if (i < 6'd11) c = asc(dig(32'(t.hour), 3'(6'd10 - i)));
        else if (i < 6'd13) c = asc(dig(32'(t.minute), 3'(6'd12 - i)));
        else if (i < 6'd15) c = asc(dig(32'(t.second), 3'(6'd14 - i)));
        return c;
    endfunction : tc_char

    // Capture records live in the memory; a capture read points it at the addressed channel.
    assign mem_raddr = (reg_rd && reg_addr[7:6] == `TTP_CAP_WIN) ? reg_addr[5:4] : r.sel_ch;
    ttp_cap_mem #(.WIDTH(TOD_W), .DEPTH(NUM_CH), .AW(2)) u_mem (
        .clk(clk),
        .reset(reset),
        .we(ev_rise),
        .wdata(r.tod),
        .raddr(mem_raddr),
        .rdata(mem_q)
    );
    assign cap_q = ttp_tod_t'(mem_q);

    // An input rise counts once the second and third stages both read high.
    assign ev_rise = r.s2 & r.s3 & ~r.stab;
    assign usec_tick = (r.cyc == CYC_LAST);
    assign sec_tick = usec_tick && (r.tod.usec == USEC_LAST);
    assign eff_period = (r.period == 32'h0) ? 32'h1 : r.period;
    assign start_reached = tod_ge(tod_adv, r.start);

    // Time of day advances by one microsecond per prescaler wrap, with calendar carries.
    always_comb begin
        tod_adv = r.tod;
        if (usec_tick) begin
            tod_adv.usec = r.tod.usec + 20'h1;
            if (sec_tick) begin
                tod_adv.usec = '0;
                tod_adv.second = r.tod.second + 6'h1;
                if (r.tod.second >= 6'd59) begin
                    tod_adv.second = '0;
                    tod_adv.minute = r.tod.minute + 6'h1;
                    if (r.tod.minute >= 6'd59) begin
                        tod_adv.minute = '0;
                        tod_adv.hour = r.tod.hour + 5'h1;
                        if (r.tod.hour >= 5'd23) begin
                            tod_adv.hour = '0;
                            tod_adv.day = r.tod.day + 5'h1;
                            if (r.tod.day >= mlen(r.tod.year, r.tod.month)) begin
                                tod_adv.day = `TTP_DAY_RST;
                                tod_adv.month = r.tod.month + 4'h1;
                                if (r.tod.month >= 4'd12) begin
                                    tod_adv.month = `TTP_MONTH_RST;
                                    tod_adv.year = r.tod.year + 16'h1;
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    // Next state: synchronisers, captures, registers, clock and pulse scheduling.
    always_comb begin
        logic [3:0] st_set;
        logic [3:0] st_clr;
        logic rearm;
        st_set = '0;
        st_clr = '0;
        rearm = 1'b0;
        r_nxt = r;
        r_nxt.s1 = event_in;
        r_nxt.s2 = r.s1;
        r_nxt.s3 = r.s2;
        for (int i = 0; i < NUM_CH; i++) begin
            if (r.s2[i] == r.s3[i]) r_nxt.stab[i] = r.s3[i];
        end
        r_nxt.cyc = usec_tick ? 8'h0 : r.cyc + 8'h1;
        r_nxt.tod = tod_adv;
        r_nxt.rd_cap = 1'b0;
        r_nxt.rd_char = 1'b0;
        r_nxt.rdata = '0;
        // Register writes.
        if (reg_wr) begin
            case (reg_addr)
                `TTP_REG_CTRL: begin
                    r_nxt.ascii = reg_wdata[`TTP_CTRL_ASCII];
                    r_nxt.cont = reg_wdata[`TTP_CTRL_CONT];
                    rearm = reg_wdata[`TTP_CTRL_CONT] && !r.cont;
                    if (reg_wdata[`TTP_CTRL_CLEAR]) begin
                        r_nxt.valid = '0;
                        r_nxt.cnt = '0;
                    end
                    if (reg_wdata[`TTP_CTRL_LOAD]) begin
                        r_nxt.tod = r.set;
                        r_nxt.cyc = '0;
                    end
                end
                `TTP_REG_STATUS: st_clr = reg_wdata[3:0];
                `TTP_REG_MASK: r_nxt.mask = reg_wdata[3:0];
                `TTP_REG_PERIOD: r_nxt.period = reg_wdata;
                `TTP_REG_START_DATE: begin
                    r_nxt.start.year = reg_wdata[`TTP_DATE_YEAR_LSB +: 16];
                    r_nxt.start.month = reg_wdata[`TTP_DATE_MON_LSB +: 4];
                    r_nxt.start.day = reg_wdata[`TTP_DATE_DAY_LSB +: 5];
                    rearm = r.cont;
                end
                `TTP_REG_START_TIME: begin
                    r_nxt.start.hour = reg_wdata[`TTP_TIME_HOUR_LSB +: 5];
                    r_nxt.start.minute = reg_wdata[`TTP_TIME_MIN_LSB +: 6];
                    r_nxt.start.second = reg_wdata[`TTP_TIME_SEC_LSB +: 6];
                    rearm = r.cont;
                end
                `TTP_REG_SET_DATE: begin
                    r_nxt.set.year = reg_wdata[`TTP_DATE_YEAR_LSB +: 16];
                    r_nxt.set.month = reg_wdata[`TTP_DATE_MON_LSB +: 4];
                    r_nxt.set.day = reg_wdata[`TTP_DATE_DAY_LSB +: 5];
                end
                `TTP_REG_SET_TIME: begin
                    r_nxt.set.hour = reg_wdata[`TTP_TIME_HOUR_LSB +: 5];
                    r_nxt.set.minute = reg_wdata[`TTP_TIME_MIN_LSB +: 6];
                    r_nxt.set.second = reg_wdata[`TTP_TIME_SEC_LSB +: 6];
                    r_nxt.set.usec = '0;
                end
                `TTP_REG_CHAR_SEL: begin
                    r_nxt.sel_ch = reg_wdata[1:0];
                    r_nxt.sel_idx = reg_wdata[`TTP_SEL_IDX_LSB +: 6];
                end
                default: ;
            endcase
        end
        // Each event stores the time and bumps its channel count; it wins over a clear.
        for (int i = 0; i < NUM_CH; i++) begin
            if (ev_rise[i]) begin
                r_nxt.valid[i] = 1'b1;
                r_nxt.cnt[i] = r_nxt.cnt[i] + 32'h1;
                st_set[i] = 1'b1;
            end
        end
        // Register reads; capture and character reads are formed next cycle from the memory, the counts or the time of day.
        if (reg_rd) begin
            if (reg_addr[7:6] == `TTP_CAP_WIN) begin
                r_nxt.rd_cap = 1'b1;
                r_nxt.rd_ch = reg_addr[5:4];
                r_nxt.rd_word = reg_addr[3:2];
            end else begin
                case (reg_addr)
                    `TTP_REG_CTRL: r_nxt.rdata = {30'h0, r.cont, r.ascii};
                    `TTP_REG_STATUS: r_nxt.rdata = {28'h0, r.status};
                    `TTP_REG_MASK: r_nxt.rdata = {28'h0, r.mask};
                    `TTP_REG_PERIOD: r_nxt.rdata = r.period;
                    `TTP_REG_START_DATE: r_nxt.rdata = pack_date(r.start);
                    `TTP_REG_START_TIME: r_nxt.rdata = pack_time(r.start);
                    `TTP_REG_SET_DATE: r_nxt.rdata = pack_date(r.tod);
                    `TTP_REG_SET_TIME: r_nxt.rdata = pack_time(r.tod);
                    `TTP_REG_CHAR_SEL: r_nxt.rdata = {18'h0, r.sel_idx, 6'h0, r.sel_ch};
                    `TTP_REG_CHAR_DATA: begin
                        r_nxt.rd_char = 1'b1;
                        r_nxt.rd_ch = r.sel_ch;
                        r_nxt.rd_idx = r.sel_idx;
                    end
                    `TTP_REG_USEC: r_nxt.rdata = {12'h0, r.tod.usec};
                    default: r_nxt.rdata = '0;
                endcase
            end
        end
        // Pulse scheduling runs on the one-second boundaries of the time base.
        case (r.pstate)
            PS_IDLE: begin
                if (rearm) r_nxt.pstate = PS_ARMED;
            end
            PS_ARMED: begin
                if (!r.cont) r_nxt.pstate = PS_IDLE;
                else if (sec_tick && start_reached) begin
                    r_nxt.pstate = PS_RUN;
                    r_nxt.pulse = 1'b1;
                    r_nxt.pw = '0;
                    r_nxt.pcnt = eff_period - 32'h1;
                    st_set[`TTP_STAT_PULSE] = 1'b1;
                end
            end
            PS_RUN: begin
                if (!r.cont) r_nxt.pstate = PS_IDLE;
                else if (rearm) r_nxt.pstate = PS_ARMED;
                else if (sec_tick) begin
                    if (r.pcnt == 32'h0) begin
                        r_nxt.pulse = 1'b1;
                        r_nxt.pw = '0;
                        r_nxt.pcnt = eff_period - 32'h1;
                    end else begin
                        r_nxt.pcnt = r.pcnt - 32'h1;
                    end
                end
            end
            default: r_nxt.pstate = PS_IDLE;
        endcase
        if (r.pulse && r_nxt.pw == r.pw) begin
            r_nxt.pw = r.pw + 16'h1;
            if (r.pw == PW_LAST) r_nxt.pulse = 1'b0;
        end
        // Set wins over a write-one clear.
        r_nxt.status = (r.status & ~st_clr) | st_set;
    end

    // State register with constant reset values.
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.period <= `TTP_PERIOD_RST;
            r.tod.month <= `TTP_MONTH_RST;
            r.tod.day <= `TTP_DAY_RST;
        end else begin
            r <= r_nxt;
        end
    end

    // Capture word and text character, formed from the memory read register, the counts or the time of day.
    always_comb begin
        cap_word = '0;
        if (!r.ascii && r.rd_ch != `TTP_TC_CH && r.valid[r.rd_ch]) begin
            case (r.rd_word)
                2'h0: cap_word = pack_date(cap_q);
                2'h1: cap_word = pack_time(cap_q);
                2'h2: cap_word = {12'h0, cap_q.usec};
                default: cap_word = r.cnt[r.rd_ch];
            endcase
        end
        char_out = 8'h00;
        if (r.ascii) begin
            if (r.rd_ch == `TTP_TC_CH) char_out = tc_char(r.tod, r.rd_idx);
            else if (r.valid[r.rd_ch]) char_out = rec_char(cap_q, r.cnt[r.rd_ch], r.rd_idx);
        end
    end

    assign reg_rdata = r.rd_cap ? cap_word : (r.rd_char ? {24'h0, char_out} : r.rdata);
    assign pulse_out = r.pulse;
    assign irq = |(r.status & r.mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_char_read(logic [1:0] ch, logic [5:0] idx);
        reg_rd && reg_addr == `TTP_REG_CHAR_DATA && r.sel_ch == ch && r.sel_idx == idx;
    endsequence

    AST_CAPTURE: assert property (ev_rise[0] |=> r.valid[0] ##1 1'b1)
        else $error("capture did not mark channel valid");
    AST_CLEAR: assert property (reg_wr && reg_addr == `TTP_REG_CTRL &&
        reg_wdata[`TTP_CTRL_CLEAR] && ev_rise == '0 |=> r.valid == '0)
        else $error("capture clear left a record");
    AST_BINARY_TEXT: assert property (s_char_read(`TTP_TC_CH, 6'd0) ##0 !r.ascii
        |=> reg_rdata == 32'h0)
        else $error("text read outside ascii format");
    AST_RECORD_COMMA: assert property (s_char_read(2'h1, 6'd4) ##0 (r.ascii && r.valid[1]
        && !reg_wr) |=> reg_rdata == 32'h0000_002c)
        else $error("record separator wrong");
    AST_TIME_CODE: assert property (s_char_read(`TTP_TC_CH, 6'd0) ##0 r.ascii
        |=> reg_rdata == 32'h0000_0054)
        else $error("time code does not start with T");
    AST_PERIOD_LOAD: assert property ($rose(r.pulse) |-> r.pcnt == eff_period - 32'h1)
        else $error("period count not loaded on pulse");
    AST_CONTINUOUS: assert property (r.pstate == PS_RUN && r.cont && sec_tick &&
        r.pcnt == 32'h0 && !reg_wr |=> r.pulse && r.pw == 16'h0)
        else $error("continuous train missed a pulse");
    AST_START: assert property (r.pstate == PS_ARMED && r.cont && sec_tick &&
        start_reached |=> r.pstate == PS_RUN && r.pulse)
        else $error("train did not start at start moment");
    AST_HOLD: assert property (r.pstate == PS_ARMED && r.cont && !reg_wr &&
        !(sec_tick && start_reached) |=> r.pstate == PS_ARMED)
        else $error("train left armed state early");
    AST_ALIGN: assert property ($rose(r.pulse) |-> $past(sec_tick))
        else $error("pulse not on a second boundary");
endmodule : ttp_scheduler

// *** tb/ttp_host_model.sv ***
// Host side model that issues register writes and reads.
`timescale 1ns/1ps
`include "ttp_consts.svh"
module ttp_host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    // Idle bus at time zero.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One-cycle write; released lines show inverted values so stale data is never trusted.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    // One-cycle read; the answer is taken in the following cycle only.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
    // Start moment is sent as year, month, day, then hour, minute, second.
    task automatic set_start(input logic [15:0] y, input logic [3:0] mo, input logic [4:0] dy,
                             input logic [4:0] h, input logic [5:0] mi, input logic [5:0] s);
        wr(`TTP_REG_START_DATE, {y, 4'h0, mo, 3'h0, dy});
        wr(`TTP_REG_START_TIME, {11'h0, h, 2'h0, mi, 2'h0, s});
    endtask : set_start
    // Discards stale records before a measurement.
    task automatic clear(input logic [31:0] keep);
        wr(`TTP_REG_CTRL, keep | 32'h4);
    endtask : clear
endmodule : ttp_host_model

// *** tb/ttp_scheduler_tb.sv ***
// Self-checking testbench of the time-tag and pulse scheduler.
`timescale 1ns/1ps
`include "ttp_consts.svh"
module ttp_scheduler_tb import ttp_pkg::*;;
    localparam int SEC = 40;
    localparam int CYC = SEC * `TTP_CYC_PER_USEC;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] event_in = 3'h0;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, pulse_out, irq;
    int n_errors = 0;
    int checks = 0;
    int n, m;
    int commas [6] = '{4, 7, 10, 13, 16, 25};
    // Free-running 100 MHz clock.
    always #5 clk = ~clk;
    ttp_scheduler #(.NUM_CH(3), .USEC_PER_SEC(SEC)) u_ttp_scheduler (.clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .event_in(event_in), .pulse_out(pulse_out), .irq(irq));
    ttp_host_model u_ttp_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // Compares and counts.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Reads one register and compares it.
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        u_ttp_host_model.rd(a, d);
        check(d, e);
    endtask : rc
    // Selects a character of a record and compares it.
    task automatic rch(input logic [1:0] ch, input logic [5:0] i, input logic [7:0] e);
        u_ttp_host_model.wr(`TTP_REG_CHAR_SEL, {18'h0, i, 6'h0, ch});
        rc(`TTP_REG_CHAR_DATA, {24'h0, e});
    endtask : rch
    // Pulses the chosen event pins.
    task automatic fire(input logic [2:0] p);
        @(posedge clk) event_in <= p;
        repeat (8) @(posedge clk);
        event_in <= 3'h0;
        repeat (8) @(posedge clk);
    endtask : fire
    // Counts cycles until the pulse output reaches a level, bounded.
    task automatic wait_lvl(input logic v, input int lim, output int c);
        c = 0;
        while (pulse_out !== v && c < lim) begin
            @(negedge clk);
            c++;
        end
    endtask : wait_lvl
    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks=%0d errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    // Cuts a hang short.
    initial begin
        #600_000;
        n_errors++;
        complete_run();
    end
    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rc(`TTP_REG_PERIOD, 32'h1);
        rc(`TTP_REG_SET_DATE, 32'h0000_0101);
        rc(8'h30, 32'h0);
        u_ttp_host_model.wr(`TTP_REG_MASK, 32'h0);
        fire(3'b001);
        check({31'h0, irq}, 32'h0);
        u_ttp_host_model.wr(`TTP_REG_MASK, 32'h7);
        fire(3'b110);
        rc(`TTP_REG_STATUS, 32'h7);
        check({31'h0, irq}, 32'h1);
        for (int c = 0; c < 3; c++) rc(8'(8'h4c + c * 16), 32'h1);
        u_ttp_host_model.wr(`TTP_REG_STATUS, 32'h7);
        rc(`TTP_REG_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
        u_ttp_host_model.clear(32'h0);
        for (int c = 0; c < 3; c++) rc(8'(8'h4c + c * 16), 32'h0);
        rc(8'h40, 32'h0);
        // Text form of a capture record and of the time code.
        u_ttp_host_model.wr(`TTP_REG_CTRL, 32'h1);
        fire(3'b010);
        rc(8'h50, 32'h0);
        foreach (commas[k]) rch(2'h1, 6'(commas[k]), 8'h2c);
        rch(2'h1, 6'd0, 8'h30);
        rch(2'h1, 6'd33, 8'h31);
        rch(2'h1, 6'd34, 8'h00);
        rch(2'h3, 6'd0, 8'h54);
        rch(2'h3, 6'd6, 8'h31);
        u_ttp_host_model.clear(32'h0);
        rch(2'h3, 6'd0, 8'h00);
        // Future start: idle until third second, then a train.
        u_ttp_host_model.wr(`TTP_REG_SET_DATE, 32'h0000_0101);
        u_ttp_host_model.wr(`TTP_REG_SET_TIME, 32'h0);
        u_ttp_host_model.wr(`TTP_REG_CTRL, 32'h8);
        u_ttp_host_model.set_start(16'h0, 4'h1, 5'h01, 5'h0, 6'h0, 6'h3);
        rc(`TTP_REG_START_DATE, 32'h0000_0101);
        rc(`TTP_REG_START_TIME, 32'h0000_0003);
        u_ttp_host_model.wr(`TTP_REG_CTRL, 32'h2);
        wait_lvl(1'b1, 5 * CYC, n);
        check(32'(n > 3 * CYC - 40 && n < 3 * CYC), 32'h1);
        wait_lvl(1'b0, 3000, n);
        check(32'(n), 32'(`TTP_PULSE_CYCLES));
        wait_lvl(1'b1, 2 * CYC, m);
        check(32'(n + m), 32'(CYC));
        rc(`TTP_REG_STATUS, 32'h0000_000a);
        u_ttp_host_model.wr(`TTP_REG_PERIOD, 32'h2);
        wait_lvl(1'b0, 3000, n);
        wait_lvl(1'b1, 3 * CYC, n);
        wait_lvl(1'b0, 3000, n);
        wait_lvl(1'b1, 3 * CYC, m);
        check(32'(n + m), 32'(2 * CYC));
        // Past start: the train begins within one second.
        u_ttp_host_model.wr(`TTP_REG_CTRL, 32'h0);
        wait_lvl(1'b0, 3000, n);
        u_ttp_host_model.set_start(16'h0, 4'h1, 5'h01, 5'h0, 6'h0, 6'h0);
        u_ttp_host_model.wr(`TTP_REG_CTRL, 32'h2);
        wait_lvl(1'b1, 2 * CYC, n);
        check(32'(n <= CYC + 20), 32'h1);
        complete_run();
    end
endmodule : ttp_scheduler_tb
